//--- bench/dcm_ctl_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcm_params.svh"
module dcm_ctl_checker import dcm_pkg::*; #(
   parameter int unsigned AW = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic link_clk,
   input wire logic te_gpio,
   input wire logic [1:0] te_inband,
   input wire logic [1:0] turnaround_done,
   input wire dcm_lane_s [1:0] lane,
   input wire logic [1:0] px_valid,
   input wire logic [15:0] px_x,
   input wire logic [15:0] px_y,
   input wire logic [15:0] left_depth
);
   logic wr_acc;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Accepted write strobe
   assign wr_acc = psel && penable && pwrite && pready;
   // Bus answer shape
   property p_rdy_req; pready |-> psel && penable; endproperty
   a_rdy_req: assert property (p_rdy_req) else $error("pready outside access");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
   property p_rdy_wait; $rose(pready) |-> $past(psel && penable && !pready); endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("no wait state");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   property p_err_hi; pready && paddr[7] |-> pslverr && prdata == 32'h0; endproperty
   a_err_hi: assert property (p_err_hi) else $error("high address not refused");
   // Link side behaviour
   property p_fip_pix; $rose(lane[0].hs) |-> ##[0:40] px_valid[0]; endproperty
   a_fip_pix: assert property (p_fip_pix) else $error("frame without pixels");
   property p_ulps00;
      lane[0].lp == `DCM_LP00 |-> $past(lane[0].lp) inside {`DCM_LP00, `DCM_LP10};
   endproperty
   a_ulps00: assert property (p_ulps00) else $error("LP-00 without escape");
   property p_depth; $changed(left_depth) |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
   a_depth: assert property (p_depth) else $error("depth moved without write");
   property p_lag; $fell(lane[0].hs) |-> lane[1].hs; endproperty
   a_lag: assert property (p_lag) else $error("slave ended before master");
endmodule : dcm_ctl_checker
bind dcm_ctl dcm_ctl_checker #(.AW(AW)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .te_gpio(te_gpio),
   .te_inband(te_inband), .turnaround_done(turnaround_done), .lane(lane),
   .px_valid(px_valid), .px_x(px_x), .px_y(px_y), .left_depth(left_depth)
);
`default_nettype wire

//--- bench/dcm_ctl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcm_params.svh"
module dcm_ctl_tb import dcm_pkg::*;;
   localparam logic [7:0] TR = {2'h0, `DCM_A_TRANS};
   localparam logic [7:0] FN = {2'h0, `DCM_A_FUNC};
   localparam logic [7:0] MD = {2'h0, `DCM_A_MODE};
   localparam logic [7:0] FR = {2'h0, `DCM_A_FRAME};
   localparam logic [7:0] LP = {2'h0, `DCM_A_LPMSG};
   localparam logic [7:0] CF = {2'h0, `DCM_A_CFG};
   localparam logic [7:0] TM = {2'h0, `DCM_A_TIMING};
   localparam logic [7:0] SP = {2'h0, `DCM_A_SPLIT};
   localparam logic [7:0] P1 = 8'h40;
   logic ref_clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic te_gpio;
   logic [1:0] te_inband, turnaround_done, px_valid;
   logic [15:0] px_x, px_y, left_depth;
   dcm_lane_s [1:0] lane;
   int err_count = 0, total_checks = 0, cyc = 0, pix = 0, mx = 0, l0 = 0, l1 = 0, n;
   int pix1 = 0, my = 0;
   // Core and link clocks
   always #2.5 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   dcm_ctl #(.BRINGUP_CYC(4), .TGSETUP_CYC(4), .ESC_CYC(2), .LAG_CYC(2)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .te_gpio(te_gpio),
      .te_inband(te_inband), .turnaround_done(turnaround_done), .lane(lane),
      .px_valid(px_valid), .px_x(px_x), .px_y(px_y), .left_depth(left_depth)
   );
   dcm_panel u_panel (
      .ref_clk(ref_clk), .te_gpio(te_gpio), .te_inband(te_inband),
      .turnaround_done(turnaround_done)
   );
   // Pixel counting and hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (px_valid[0] === 1'b1) begin
         pix <= pix + 1;
         l0 <= cyc;
         if (px_x > mx) mx <= px_x;
         if (px_y > my) my <= px_y;
      end
      if (px_valid[1] === 1'b1) pix1 <= pix1 + 1;
      if (lane[1].hs === 1'b1) l1 <= cyc;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task test_done();
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, x);
      end
   endtask : chk
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task poll(input logic [7:0] a, input int b, input logic v);
      int k;
      k = 0;
      do begin
         rd(a);
         k++;
      end while (q[b] !== v && k < 100);
      chk(q[b], v);
   endtask : poll
   task wpix(input int t);
      int k;
      k = 0;
      while (pix < t && k < 3000) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (20) @(posedge ref_clk);
      chk(pix, t);
   endtask : wpix
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(FR); chk(q[`DCM_B_PERIODIC], 1'b0);
      rd(8'h20); chk({e, q[30:0]}, 32'h8000_0000);
      wr(8'h80, 32'h1); chk(e, 1'b1);
      rd(TR); chk(q, 32'h0000_0000);
      wr(FN, 32'h3); poll(CF, `DCM_B_LINK_RDY, 1'b1);
      wr(TM, 32'h0002_0004);
      wr(SP, 32'h0000_0102);
      rd(SP); chk(q[31:16], 16'h0002);
      chk(left_depth, 16'h0002);
      wr(SP, 32'h0005_0102); rd(SP); chk(q[31:16], 16'h0005);
      rd(P1 | TM); chk(q, 32'h0002_0004);
      wr(LP, 32'h4); poll(LP, `DCM_B_PANEL_OWN, 1'b1);
      u_panel.bus_back(0); poll(LP, `DCM_B_PANEL_OWN, 1'b0);
      wr(P1 | LP, 32'h4); poll(P1 | LP, `DCM_B_PANEL_OWN, 1'b1);
      u_panel.bus_back(1); poll(P1 | LP, `DCM_B_PANEL_OWN, 1'b0);
      // Non-gating frame, dual link width
      wr(MD, 32'h2); wr(TR, 32'h1); wr(FR, 32'h1); rd(FR);
      chk(q[`DCM_B_REQ], 1'b0);
      chk(q[`DCM_B_FIP], 1'b1);
      wpix(12); chk(mx, 5);
      chk(my, 1);
      chk(pix1, 12);
      chk(l1 > l0, 1);
      poll(FR, `DCM_B_FIP, 1'b0);
      // Gated by sideband TE
      wr(MD, 32'h1); wr(FR, 32'h1); repeat (60) @(posedge ref_clk); chk(pix, 12);
      u_panel.te_out(); wpix(24);
      // Periodic updates, two TE events
      wr(MD, 32'h2); wr(FR, 32'h2);
      u_panel.te_out(); wpix(36);
      u_panel.te_out(); wpix(48);
      wr(FR, 32'h0);
      // In-band gating
      wr(MD, 32'h5); wr(FR, 32'h1); wr(P1 | LP, 32'h4);
      u_panel.te_in(0); u_panel.bus_back(1);
      repeat (60) @(posedge ref_clk); chk(pix, 48);
      u_panel.te_in(1); wpix(60);
      // In-band non-gating, turnaround after frame
      wr(MD, 32'h6); wr(FR, 32'h1); wpix(72); poll(FR, `DCM_B_FIP, 1'b0);
      wr(P1 | LP, 32'h4); u_panel.bus_back(1);
      // LP-00 low power entry and exit
      wr(TR, 32'h0); poll(TR, `DCM_B_ON, 1'b0);
      wr(LP, 32'h1); poll(LP, `DCM_B_IN_ULPS, 1'b1);
      chk(lane[0].lp, `DCM_LP00);
      rd(P1 | LP); chk(q[`DCM_B_IN_ULPS], 1'b0);
      wr(FN, 32'h2); rd(LP); chk(q[`DCM_B_IN_ULPS], 1'b0);
      // Switch to video through LP-11
      wr(FN, 32'h3); poll(CF, `DCM_B_LINK_RDY, 1'b1);
      wr(LP, 32'h3); poll(LP, `DCM_B_IN_ULPS, 1'b1); chk(lane[0], 32'h3);
      wr(FN, 32'h2); wr(MD, 32'h0); wr(FN, 32'h3);
      rd(CF); chk(q[`DCM_B_LINK_RDY], 1'b1);
      wr(TR, 32'h1); repeat (300) @(posedge ref_clk); chk(pix > 72, 1);
      test_done();
   end
endmodule : dcm_ctl_tb
`default_nettype wire

//--- bench/dcm_panel.sv
`timescale 1ns/10ps
`default_nettype none
module dcm_panel (
   input wire logic ref_clk,
   output logic te_gpio,
   output logic [1:0] te_inband,
   output logic [1:0] turnaround_done
);
   // Quiet panel at start
   initial begin
      te_gpio = 1'b0;
      te_inband = 2'h0;
      turnaround_done = 2'h0;
   end
   // Sideband TE pulse
   task te_out();
      @(posedge ref_clk) te_gpio <= 1'b1;
      repeat (8) @(posedge ref_clk);
      te_gpio <= 1'b0;
   endtask : te_out
   task te_in(input int p);
      @(posedge ref_clk) te_inband[p] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      te_inband[p] <= 1'b0;
   endtask : te_in
   task bus_back(input int p);
      @(posedge ref_clk) turnaround_done[p] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      turnaround_done[p] <= 1'b0;
   endtask : bus_back
endmodule : dcm_panel
`default_nettype wire

//--- hdl/_unused_placeholder_never.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- hdl/dcm_ctl.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dcm_params.svh"
// Functional notes
// - Gating with GPIO TE holds the frame until the next GPIO TE edge.
// - Non-gating mode starts the frame at once on a request.
// - In-band gating sends after TE seen and the panel returned the bus.
// - Periodic mode starts a frame by itself on a GPIO TE rising edge seen while idle.
// - Periodic mode is off after reset.
// - Dual link mirrors master configuration writes into the slave.
// - Message and response registers stay per port.
// - Slave frame-in-progress falls after the master's.
// - Front/back split with zero left depth uses half the width.
// - Dual link line length is the programmed half plus overlap.
// - Function re-enable skips bring-up when the link is ready.
// - Video frames start only after timing generator setup.
// - LP-00 ULPS drives the lane of its own port to LP-00 via escape entry.
// - LP-11 ULPS locks the lane of its own port in the stop state.
// - Hardware clears the frame request once it takes it.
// - In-ULPS status stays set until the function is disabled.
module dcm_ctl import dcm_pkg::*; #(
   parameter int unsigned AW = 8,
   parameter int unsigned LAG_CYC = `DCM_CYC(`DCM_LAG_NS),
   parameter int unsigned BRINGUP_CYC = `DCM_CYC(`DCM_BRINGUP_NS),
   parameter int unsigned TGSETUP_CYC = `DCM_CYC(`DCM_TGSETUP_NS),
   parameter int unsigned ESC_CYC = `DCM_CYC(`DCM_ESC_NS)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk,
   input wire logic te_gpio,
   input wire logic [1:0] te_inband,
   input wire logic [1:0] turnaround_done,
   output var dcm_lane_s [1:0] lane,
   output logic [1:0] px_valid,
   output logic [15:0] px_x,
   output logic [15:0] px_y,
   output logic [15:0] left_depth
);
   if (AW < 7 || LAG_CYC < 1 || LAG_CYC > 65535 || BRINGUP_CYC > 65535 || TGSETUP_CYC > 65535 ||
       ESC_CYC < 1 || ESC_CYC > 65535) begin : g_chk
      $error("dcm_ctl: parameter out of range");
   end

   logic [5:0] sy1;
   logic [5:0] sy2;
   logic [5:0] sy3;
   logic [5:0] rise;
   logic wr;
   logic wport;
   logic [5:0] woff;
   logic [1:0] tc_en;
   logic [1:0] fn_en;
   logic [1:0] fn_q;
   logic dual;
   logic [1:0][1:0] mode;
   logic [1:0] te_src;
   logic [1:0][15:0] hact;
   logic [1:0][15:0] vact;
   logic [7:0] ovl;
   logic fb;
   logic [15:0] ldep_sw;
   logic req;
   logic periodic;
   dcm_frm_e fst;
   logic [15:0] fcnt;
   logic [15:0] x;
   logic [15:0] y;
   logic [15:0] line_len;
   logic te_seen;
   logic s_fip;
   logic [15:0] lag;
   logic m_fip;
   logic step;
   dcm_lp_e [1:0] lst;
   logic [1:0][15:0] lcnt;
   logic [1:0][15:0] bcnt;
   logic [1:0] link_rdy;
   logic [1:0] ulps_req;
   logic [1:0] ulps_type;
   logic [1:0] bta_req;
   logic [1:0] lp_busy;
   logic [1:0] in_ulps;
   logic [1:0] panel_own;
   logic ib_port;
   logic bad;

   // Registers copied master to slave in dual link
   function automatic logic mirrored(input logic [5:0] off);
      mirrored = (off == `DCM_A_TRANS) || (off == `DCM_A_FUNC) || (off == `DCM_A_MODE) ||
                 (off == `DCM_A_TIMING);
   endfunction : mirrored

   // Write strobe for one port, with mirroring
   function automatic logic hit(input logic p, input logic [5:0] off);
      hit = wr && (woff == off) && ((wport == p) || (p && !wport && dual && mirrored(off)));
   endfunction : hit

   // Refused writes never reach a register
   assign wr = psel && penable && pready && pwrite && !pslverr;
   // Unmapped, unaligned or out-of-window address
   assign bad = (woff > `DCM_A_SPLIT) || (woff[1:0] != 2'h0) ||
                (paddr[AW-1:`DCM_PORT_BIT+1] != '0);
   assign wport = paddr[`DCM_PORT_BIT];
   assign woff = paddr[5:0];
   assign rise = sy2 & ~sy3;
   assign step = rise[0];
   assign m_fip = (fst == F_SEND);
   assign ib_port = dual;
   assign line_len = hact[0] + (dual ? {8'h00, ovl} : 16'h0000);

   // Pin synchronisers and edge detect
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sy1 <= 6'h00;
         sy2 <= 6'h00;
         sy3 <= 6'h00;
      end else begin
         sy1 <= {turnaround_done, te_inband, te_gpio, link_clk};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   // APB slave, one wait state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && bad;
         prdata <= 32'h0000_0000;
         // Refused reads return zero
         if (psel && penable && !pready && !pwrite && !bad) begin
            case (woff)
               `DCM_A_TRANS: prdata <= {1'b0, tc_en[wport] | (wport ? s_fip : m_fip), 29'h0,
                                        tc_en[wport]};
               `DCM_A_FUNC: prdata <= {30'h0, dual & ~wport, fn_en[wport]};
               `DCM_A_MODE: prdata <= {29'h0, te_src[wport], mode[wport]};
               `DCM_A_FRAME: prdata <= {29'h0, wport ? s_fip : m_fip, periodic & ~wport,
                                        req & ~wport};
               `DCM_A_LPMSG: prdata <= {21'h0, panel_own[wport], in_ulps[wport], lp_busy[wport],
                                        5'h00, bta_req[wport], ulps_type[wport], ulps_req[wport]};
               `DCM_A_CFG: prdata <= {31'h0, link_rdy[wport]};
               `DCM_A_TIMING: prdata <= {vact[wport], hact[wport]};
               `DCM_A_SPLIT: prdata <= wport ? 32'h0 : {left_depth, 7'h00, fb, ovl};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Configuration registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tc_en <= 2'h0;
         fn_en <= 2'h0;
         dual <= 1'b0;
         mode <= '0;
         te_src <= 2'h0;
         hact <= '0;
         vact <= '0;
         ovl <= 8'h00;
         fb <= 1'b0;
         ldep_sw <= 16'h0000;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (hit(p[0], `DCM_A_TRANS)) begin
               tc_en[p] <= pwdata[`DCM_B_EN];
            end
            if (hit(p[0], `DCM_A_FUNC)) begin
               fn_en[p] <= pwdata[`DCM_B_EN];
            end
            if (hit(p[0], `DCM_A_MODE)) begin
               mode[p] <= pwdata[1:0];
               te_src[p] <= pwdata[`DCM_B_TESRC];
            end
            if (hit(p[0], `DCM_A_TIMING)) begin
               hact[p] <= pwdata[15:0];
               vact[p] <= pwdata[31:16];
            end
         end
         if (hit(1'b0, `DCM_A_FUNC)) begin
            dual <= pwdata[`DCM_B_DUAL];
         end
         if (hit(1'b0, `DCM_A_SPLIT)) begin
            ovl <= pwdata[7:0];
            fb <= pwdata[`DCM_B_FB];
            ldep_sw <= pwdata[31:16];
         end
      end
   end

   // Left buffer depth, defaulted to half width in front/back split
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         left_depth <= 16'h0000;
      end else begin
         left_depth <= (fb && ldep_sw == 16'h0000) ? {1'b0, hact[0][15:1]} : ldep_sw;
      end
   end

   // Master frame dispatch engine
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fst <= F_IDLE;
         periodic <= 1'b0;
         req <= 1'b0;
         fcnt <= 16'h0000;
         x <= 16'h0000;
         y <= 16'h0000;
         te_seen <= 1'b0;
      end else begin
         if (hit(1'b0, `DCM_A_FRAME)) begin
            periodic <= pwdata[`DCM_B_PERIODIC];
         end
         // In-band TE of the owning port
         if (rise[2 + {1'b0, ib_port}]) begin
            te_seen <= 1'b1;
         end
         case (fst)
            F_IDLE: begin
               te_seen <= 1'b0;
               x <= 16'h0000;
               y <= 16'h0000;
               if (tc_en[0] && fn_en[0] && link_rdy[0]) begin
                  if (mode[0] == `DCM_MODE_VIDEO) begin
                     fcnt <= TGSETUP_CYC[15:0];
                     fst <= F_SETUP;
                  end else if (req) begin
                     req <= 1'b0;
                     fst <= (mode[0] == `DCM_MODE_GATE) ? F_HOLD : F_SEND;
                  end else if (periodic && rise[1]) begin
                     fst <= F_SEND;
                  end
               end
            end
            F_HOLD: begin
               if (!tc_en[0]) begin
                  fst <= F_IDLE;
               end else if (!te_src[0] && rise[1]) begin
                  fst <= F_SEND;
               end else if (te_src[0] && te_seen && !panel_own[ib_port] && !bta_req[ib_port]) begin
                  fst <= F_SEND;
               end
            end
            F_SETUP: begin
               if (!tc_en[0]) begin
                  fst <= F_IDLE;
               end else if (fcnt <= 16'h0001) begin
                  fst <= F_SEND;
               end else begin
                  fcnt <= fcnt - 16'h0001;
               end
            end
            F_SEND: begin
               if (step) begin
                  if (x + 16'h0001 >= line_len) begin
                     x <= 16'h0000;
                     if (y + 16'h0001 >= vact[0]) begin
                        y <= 16'h0000;
                        fst <= (mode[0] == `DCM_MODE_VIDEO && tc_en[0]) ? F_SEND : F_IDLE;
                     end else begin
                        y <= y + 16'h0001;
                     end
                  end else begin
                     x <= x + 16'h0001;
                  end
               end
            end
            default: fst <= F_IDLE;
         endcase
         // New software request wins over the clear
         if (hit(1'b0, `DCM_A_FRAME) && pwdata[`DCM_B_REQ]) begin
            req <= 1'b1;
         end
      end
   end

   // Slave frame-in-progress trails the master
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_fip <= 1'b0;
         lag <= 16'h0000;
      end else begin
         if (m_fip && dual) begin
            s_fip <= 1'b1;
            lag <= LAG_CYC[15:0];
         end else if (s_fip) begin
            if (lag <= 16'h0001) begin
               s_fip <= 1'b0;
            end else begin
               lag <= lag - 16'h0001;
            end
         end
      end
   end

   // Per-port low-power message and link bring-up engines
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lst[0] <= L_IDLE;
         lst[1] <= L_IDLE;
         lcnt <= '0;
         bcnt <= '0;
         fn_q <= 2'h0;
         link_rdy <= 2'h0;
         ulps_req <= 2'h0;
         ulps_type <= 2'h0;
         bta_req <= 2'h0;
         lp_busy <= 2'h0;
         in_ulps <= 2'h0;
         panel_own <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            fn_q[p] <= fn_en[p];
            if (fn_en[p] && !fn_q[p] && !link_rdy[p]) begin
               bcnt[p] <= BRINGUP_CYC[15:0];
            end else if (bcnt[p] != 16'h0000) begin
               bcnt[p] <= bcnt[p] - 16'h0001;
               if (bcnt[p] == 16'h0001) begin
                  link_rdy[p] <= fn_en[p];
               end
            end else if (fn_en[p] && !link_rdy[p] && BRINGUP_CYC == 0) begin
               link_rdy[p] <= 1'b1;
            end
            if (!fn_en[p] && fn_q[p] && !(in_ulps[p] && ulps_type[p])) begin
               link_rdy[p] <= 1'b0;
            end
            case (lst[p])
               L_IDLE: begin
                  if (ulps_req[p] && !tc_en[p] && !(p == 0 ? m_fip : s_fip)) begin
                     lp_busy[p] <= 1'b1;
                     lcnt[p] <= ESC_CYC[15:0];
                     lst[p] <= ulps_type[p] ? L_ULPS : L_ESC;
                  end else if (bta_req[p]) begin
                     lp_busy[p] <= 1'b1;
                     panel_own[p] <= 1'b1;
                     lst[p] <= L_BTA;
                  end
               end
               L_BTA: begin
                  if (rise[4 + p]) begin
                     panel_own[p] <= 1'b0;
                     bta_req[p] <= 1'b0;
                     lp_busy[p] <= 1'b0;
                     lst[p] <= L_IDLE;
                  end
               end
               L_ESC: begin
                  if (lcnt[p] <= 16'h0001) begin
                     lst[p] <= L_ULPS;
                  end else begin
                     lcnt[p] <= lcnt[p] - 16'h0001;
                  end
               end
               L_ULPS: begin
                  in_ulps[p] <= fn_en[p];
                  ulps_req[p] <= 1'b0;
                  if (!fn_en[p]) begin
                     lp_busy[p] <= 1'b0;
                     lst[p] <= L_IDLE;
                  end
               end
               default: lst[p] <= L_IDLE;
            endcase
            if (hit(p[0], `DCM_A_LPMSG)) begin
               ulps_req[p] <= ulps_req[p] | pwdata[`DCM_B_ULPS_REQ];
               bta_req[p] <= bta_req[p] | pwdata[`DCM_B_BTA_REQ];
               if (lst[p] == L_IDLE) begin
                  ulps_type[p] <= pwdata[`DCM_B_ULPS_TYPE];
               end
            end
         end
      end
   end

   // Lane levels and pixel strobes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lane <= '0;
         px_valid <= 2'h0;
         px_x <= 16'h0000;
         px_y <= 16'h0000;
      end else begin
         px_x <= x;
         px_y <= y;
         px_valid <= {m_fip && step && dual, m_fip && step};
         for (int p = 0; p < 2; p++) begin
            // Slave lane trails the master frame
            lane[p].hs <= (p == 0) ? m_fip : s_fip;
            if (lst[p] == L_ESC) begin
               lane[p].lp <= `DCM_LP10;
            end else if (lst[p] == L_ULPS && !ulps_type[p]) begin
               lane[p].lp <= `DCM_LP00;
            end else begin
               lane[p].lp <= `DCM_LP11;
            end
         end
      end
   end
endmodule : dcm_ctl
`default_nettype wire

//--- hdl/dcm_params.svh
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
// Register offsets within one port window
`define DCM_A_TRANS 6'h00
`define DCM_A_FUNC 6'h04
`define DCM_A_MODE 6'h08
`define DCM_A_FRAME 6'h0c
`define DCM_A_LPMSG 6'h10
`define DCM_A_CFG 6'h14
`define DCM_A_TIMING 6'h18
`define DCM_A_SPLIT 6'h1c
`define DCM_PORT_BIT 6
// Field positions
`define DCM_B_EN 0
`define DCM_B_DUAL 1
`define DCM_B_ON 30
`define DCM_B_TESRC 2
`define DCM_B_REQ 0
`define DCM_B_PERIODIC 1
`define DCM_B_FIP 2
`define DCM_B_ULPS_REQ 0
`define DCM_B_ULPS_TYPE 1
`define DCM_B_BTA_REQ 2
`define DCM_B_LP_BUSY 8
`define DCM_B_IN_ULPS 9
`define DCM_B_PANEL_OWN 10
`define DCM_B_LINK_RDY 0
`define DCM_B_FB 8
// Mode of operation codes
`define DCM_MODE_VIDEO 2'h0
`define DCM_MODE_GATE 2'h1
`define DCM_MODE_FREE 2'h2
// Lane line levels
`define DCM_LP11 2'h3
`define DCM_LP10 2'h2
`define DCM_LP00 2'h0
// Timing, in ns, and cycle counts at the core clock
`define DCM_CLK_MHZ 200
`define DCM_BRINGUP_NS 1000
`define DCM_TGSETUP_NS 500
`define DCM_ESC_NS 100
`define DCM_LAG_NS 40
`define DCM_CYC(ns) (((ns) * `DCM_CLK_MHZ + 999) / 1000)
`endif

//--- hdl/dcm_pkg.sv
package dcm_pkg;
   typedef struct packed {
      logic hs;
      logic [1:0] lp;
   } dcm_lane_s;
   typedef enum logic [2:0] {F_IDLE, F_HOLD, F_SETUP, F_SEND} dcm_frm_e;
   typedef enum logic [2:0] {L_IDLE, L_BTA, L_ESC, L_ULPS} dcm_lp_e;
endpackage : dcm_pkg
